// >>> src/hsfs_device.sv
// mapper end: low-speed clocks, composite transmit sync, receive frame start, mate lanes
// assumes CLK at 125 MHz; clock presence and frame marks come from logic on CLK
`timescale 1ns/1ps
`default_nettype none
module hsfs_device
(
    input  wire logic                  CLK,
    input  wire logic                  RST_N,
    input  wire logic                  TX_HS_REF_OK,
    input  wire logic                  RX_HS_CLOCK_IN,
    input  wire logic                  RATE_622,
    input  wire logic                  CDR_BYPASS,
    input  wire logic [4:0]            CDR_LOCK,
    input  wire logic                  SYNC_MASTER_SELECT,
    input  wire hsfs_pkg::hsfs_pos_t   TX_FRAME_OFFSET,
    input  wire logic                  RX_FRAME_MARK,
    input  wire logic                  RX_FRAME_VALID,
    input  wire hsfs_pkg::hsfs_lane_t  XC_MATE_DATA,
    output logic [4:0]                 CDR_REF_OK,
    output logic [4:0]                 CDR_RATE_622,
    output logic                       FRAMER_MCLK_OK,
    output logic                       RX_LOWSPEED_CLOCK,
    output logic                       TX_LOWSPEED_CLOCK,
    output logic                       TX_LS_TICK,
    output logic                       RX_FRAME_START_N,
    output logic                       TX_FRAME_START,
    output hsfs_pkg::hsfs_pos_t        TX_FRAME_POS,
    output logic                       SYNC_EDGE,
    output hsfs_pkg::hsfs_lane_t       MATE_TX_DATA,
    hsfs_if.dev                        link
);
    import hsfs_pkg::*;

    localparam hsfs_pos_t FRAME_LAST = 12'(`HSFS_FRAME_TICKS - 1);
    localparam hsfs_mf_t  MF_LAST    = 2'(`HSFS_MF_FRAMES - 1);
    localparam logic [6:0] RFS_LEN   = 7'(`HSFS_RFS_CYC);

    // clock sources
    logic       rxclk_s1_q;
    logic       rxclk_s2_q;
    logic       rx_src_ok;
    logic [1:0] nco_run;
    logic [1:0] nco_tick;
    logic [1:0] nco_lvl;

    // the external receive clock is ignored whenever 622 runs or CDR is in use
    assign rx_src_ok = (RATE_622 | ~CDR_BYPASS) ? CDR_LOCK[0] : rxclk_s2_q;
    assign nco_run   = {rx_src_ok, TX_HS_REF_OK};

    // 125 MHz has no integer ratio to 19.44 MHz, so a phase accumulator is used;
    // edges jitter by one system cycle but the average rate is exact
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_nco
            logic [13:0] acc_q;
            logic [14:0] sum;
            assign sum         = {1'b0, acc_q} + {1'b0, `HSFS_NCO_STEP};
            assign nco_tick[g] = nco_run[g] & (sum >= {1'b0, `HSFS_NCO_MOD});
            assign nco_lvl[g]  = acc_q >= `HSFS_NCO_HALF;
            always_ff @(posedge CLK or negedge RST_N)
            begin
                if (!RST_N)
                    acc_q <= 14'h0000;
                else if (nco_run[g])
                    acc_q <= nco_tick[g] ? 14'(sum - {1'b0, `HSFS_NCO_MOD}) : sum[13:0];
            end
        end
    endgenerate

    // five CDRs all referenced to the transmit clock; mate CDRs are 155 only
    generate
        for (g = 0; g < 5; g++)
        begin : g_cdr
            assign CDR_REF_OK[g]   = TX_HS_REF_OK;
            assign CDR_RATE_622[g] = (g < 2) ? RATE_622 : 1'b0;
        end
    endgenerate

    assign FRAMER_MCLK_OK = TX_HS_REF_OK;

    logic tick;
    assign tick = nco_tick[0];

    // transmit frame counter
    hsfs_pos_t pos_q;
    hsfs_pos_t pos_d;
    hsfs_mf_t  mf_q;
    hsfs_mf_t  mf_d;
    hsfs_pos_t gap_q;
    logic      master;

    // sync input path, two flops then sampling on the low-speed tick
    logic sync_s1_q;
    logic sync_s2_q;
    logic sync_ls_q;
    logic edge_ev;
    logic j0_ev;
    logic v1_ev;

    assign master  = SYNC_MASTER_SELECT;
    assign edge_ev = ~master & tick & sync_s2_q & ~sync_ls_q;
    assign j0_ev   = edge_ev & (gap_q >= `HSFS_J0_GAP);
    assign v1_ev   = edge_ev & ~j0_ev & (pos_q == `HSFS_V1_POS);

    always_comb
    begin
        pos_d = pos_q;
        mf_d  = mf_q;
        if (tick)
        begin
            if (pos_q == FRAME_LAST)
            begin
                pos_d = 12'h000;
                mf_d  = (mf_q == MF_LAST) ? 2'd0 : 2'(mf_q + 2'd1);
            end
            else
                pos_d = 12'(pos_q + 12'h001);
            if (j0_ev)
                pos_d = 12'h001;
            if (v1_ev)
                mf_d = 2'd0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rxclk_s1_q <= 1'b0;
            rxclk_s2_q <= 1'b0;
            sync_s1_q  <= 1'b0;
            sync_s2_q  <= 1'b0;
        end
        else
        begin
            rxclk_s1_q <= RX_HS_CLOCK_IN;
            rxclk_s2_q <= rxclk_s1_q;
            sync_s1_q  <= link.sync_line;
            sync_s2_q  <= sync_s1_q;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pos_q     <= 12'h000;
            mf_q      <= 2'd0;
            sync_ls_q <= 1'b0;
            gap_q     <= 12'h000;
        end
        else
        begin
            pos_q <= pos_d;
            mf_q  <= mf_d;
            if (tick)
            begin
                sync_ls_q <= sync_s2_q;
                gap_q     <= edge_ev ? 12'h000 : ((gap_q == 12'hfff) ? gap_q : 12'(gap_q + 12'h001));
            end
        end
    end

    // master drives the composite train, one low-speed period wide per marker
    logic sync_o_q;
    logic sync_oe_q;
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sync_o_q  <= 1'b0;
            sync_oe_q <= 1'b0;
        end
        else
        begin
            sync_oe_q <= master;
            if (tick)
                sync_o_q <= master & hsfs_marker_at(pos_d, mf_d);
        end
    end
    assign link.sync_dev_o  = sync_o_q;
    assign link.sync_dev_oe = sync_oe_q;

    // transmit frame placement; master timing is free so no offset applies there
    logic      tfs_q;
    hsfs_pos_t frame_at;
    assign frame_at = master ? 12'h000 : TX_FRAME_OFFSET;
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tfs_q <= 1'b0;
            TX_FRAME_POS <= 12'h000;
            SYNC_EDGE <= 1'b0;
        end
        else
        begin
            tfs_q <= tick & (pos_d == frame_at);
            TX_FRAME_POS <= pos_q;
            SYNC_EDGE <= edge_ev;
        end
    end
    assign TX_FRAME_START = tfs_q;

    // receive frame start: 63 cycles low, killed at once if framing is lost
    logic [6:0] rfs_cnt_q;
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            rfs_cnt_q <= 7'h00;
        else if (!RX_FRAME_VALID)
            rfs_cnt_q <= 7'h00;
        else if (RX_FRAME_MARK)
            rfs_cnt_q <= RFS_LEN;
        else if (rfs_cnt_q != 7'h00)
            rfs_cnt_q <= 7'(rfs_cnt_q - 7'h01);
    end
    assign RX_FRAME_START_N = (rfs_cnt_q == 7'h00);

    // low-speed clock outputs from flops
    logic [1:0] lvl_q;
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            lvl_q <= 2'b00;
        else
            lvl_q <= nco_lvl & nco_run;
    end
    assign TX_LOWSPEED_CLOCK = lvl_q[0];
    assign RX_LOWSPEED_CLOCK = lvl_q[1];
    assign TX_LS_TICK        = tick;

    // mate lanes live only on a 622 master; elsewhere they idle low
    logic                 mate_en;
    hsfs_lane_t           mate_rx_q;
    hsfs_lane_t           mate_s1_q;
    hsfs_lane_t           mate_s2_q;
    assign mate_en = master & RATE_622;
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            mate_rx_q    <= '0;
            mate_s1_q    <= '0;
            mate_s2_q    <= '0;
            MATE_TX_DATA <= '0;
        end
        else
        begin
            mate_rx_q    <= mate_en ? XC_MATE_DATA : '0;
            mate_s1_q    <= link.mate_tx;
            mate_s2_q    <= mate_s1_q;
            MATE_TX_DATA <= mate_en ? mate_s2_q : '0;
        end
    end
    assign link.mate_rx = mate_rx_q;
endmodule
`default_nettype wire

// >>> src/hsfs_cfg.svh
// constants of the transmit frame sync and low-speed clocking block
// assumes one 125 MHz system clock; high-speed clocks arrive as presence levels
// Function
// - transmit ref clocks transmit side and CDRs
// - five CDRs, two dual-rate, three 155 only
// - transmit ref also feeds framer master clock
// - receive frame start only with valid frame
// - receive frame start low for about 500 ns
// - receive low-speed 19.44 MHz from receive clock
// - transmit low-speed 19.44 MHz from transmit ref
// - composite sync marks J0, J1-1..12, V1-1
// - J0/J1 every 125 us, V1-1 every 500 us
// - master select drives sync pin, else input
// - positive pulses on low-speed clock, rising edge counts
// - up to four devices share one sync line
// - mate lanes only on master at 622
// - mate receive lanes carry crossconnect SONET data
// - slaves place mate frames fixed after sync
// - slave frame follows sync plus programmable offset
// - 622 mode always uses recovered receive clock
`ifndef HSFS_CFG_SVH
`define HSFS_CFG_SVH
`define HSFS_CLK_NS        8
`define HSFS_NCO_MOD       14'd12500
`define HSFS_NCO_STEP      14'd1944
`define HSFS_NCO_HALF      14'd6250
`define HSFS_FRAME_US      125
`define HSFS_MFRAME_US     500
`define HSFS_FRAME_TICKS   (`HSFS_FRAME_US * 1944 / 100)
`define HSFS_MF_FRAMES     (`HSFS_MFRAME_US / `HSFS_FRAME_US)
`define HSFS_J1_BASE       12'h05a
`define HSFS_J1_STEP       12'h05a
`define HSFS_J1_COUNT      12
`define HSFS_V1_POS        12'h492
`define HSFS_J0_GAP        12'h1f4
`define HSFS_MATE_OFS      12'h010
`define HSFS_RFS_NS        500
`define HSFS_RFS_CYC       ((`HSFS_RFS_NS + `HSFS_CLK_NS - 1) / `HSFS_CLK_NS)
`define HSFS_MATE_LANES    3
`endif

// >>> src/hsfs_pkg.sv
// types and sync pulse decoding shared by both ends
// assumes hsfs_cfg.svh constants
`include "hsfs_cfg.svh"
package hsfs_pkg;
    typedef logic [11:0] hsfs_pos_t;
    typedef logic [1:0]  hsfs_mf_t;
    typedef logic [`HSFS_MATE_LANES-1:0] hsfs_lane_t;

    // one pulse per marker byte position of the composite train
    function automatic logic hsfs_marker_at(input hsfs_pos_t pos, input hsfs_mf_t mf);
        logic hit;
        hit = (pos == 12'h000);
        for (int k = 1; k <= `HSFS_J1_COUNT; k++)
            if (pos == 12'(k * `HSFS_J1_STEP)) hit = 1'b1;
        if (mf == 2'd0 && pos == `HSFS_V1_POS) hit = 1'b1;
        return hit;
    endfunction
endpackage

// >>> src/hsfs_if.sv
// link between a mapper and its sync partner: shared sync wire and mate lanes
// assumes the board pull-down on the sync wire
`timescale 1ns/1ps
`default_nettype none
interface hsfs_if;
    logic                   sync_dev_o;
    logic                   sync_dev_oe;
    logic                   sync_peer_o;
    logic                   sync_peer_oe;
    logic                   sync_line;
    hsfs_pkg::hsfs_lane_t   mate_rx;
    hsfs_pkg::hsfs_lane_t   mate_tx;

    // wired sync line, pulled low when nobody drives
    assign sync_line = (sync_dev_oe & sync_dev_o) | (sync_peer_oe & sync_peer_o);

    modport dev  (output sync_dev_o, output sync_dev_oe, input sync_line,
                  output mate_rx, input mate_tx);
    modport peer (output sync_peer_o, output sync_peer_oe, input sync_line,
                  input mate_rx, output mate_tx);
endinterface
`default_nettype wire

// >>> src/hsfs_peer.sv
// partner end: another mapper or system sync on the shared sync line
// assumes CLK at 125 MHz and the same low-speed tick rate as the device
`timescale 1ns/1ps
`default_nettype none
module hsfs_peer
#(
    parameter int LANE = 0
)
(
    input  wire logic  CLK,
    input  wire logic  RST_N,
    input  wire logic  PEER_MASTER,
    output logic       PEER_LOCKED,
    output logic       PEER_J0,
    hsfs_if.peer       link
);
    import hsfs_pkg::*;

    localparam hsfs_pos_t FRAME_LAST = 12'(`HSFS_FRAME_TICKS - 1);
    localparam hsfs_mf_t  MF_LAST    = 2'(`HSFS_MF_FRAMES - 1);

    logic [13:0] acc_q;
    logic [14:0] sum;
    logic        tick;
    assign sum  = {1'b0, acc_q} + {1'b0, `HSFS_NCO_STEP};
    assign tick = sum >= {1'b0, `HSFS_NCO_MOD};

    logic      s1_q;
    logic      s2_q;
    logic      ls_q;
    hsfs_pos_t pos_q;
    hsfs_mf_t  mf_q;
    hsfs_pos_t gap_q;
    logic      j0;
    logic      wrap;
    assign j0   = ~PEER_MASTER & tick & s2_q & ~ls_q & (gap_q >= `HSFS_J0_GAP);
    assign wrap = pos_q == FRAME_LAST;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            acc_q <= 14'h0000;
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            ls_q  <= 1'b0;
            pos_q <= 12'h000;
            mf_q  <= 2'd0;
            gap_q <= 12'h000;
            PEER_LOCKED <= 1'b0;
        end
        else
        begin
            acc_q <= tick ? 14'(sum - {1'b0, `HSFS_NCO_MOD}) : sum[13:0];
            s1_q  <= link.sync_line;
            s2_q  <= s1_q;
            if (tick)
            begin
                ls_q  <= s2_q;
                gap_q <= (s2_q & ~ls_q) ? 12'h000 : ((gap_q == 12'hfff) ? gap_q : 12'(gap_q + 12'h001));
                pos_q <= j0 ? 12'h001 : (wrap ? 12'h000 : 12'(pos_q + 12'h001));
                if (wrap)
                    mf_q <= (mf_q == MF_LAST) ? 2'd0 : 2'(mf_q + 2'd1);
                if (j0)
                    PEER_LOCKED <= 1'b1;
            end
            if (PEER_MASTER)
                PEER_LOCKED <= 1'b1;
        end
    end

    // at most one master on the wire; a slave peer leaves it to the device
    logic o_q;
    logic oe_q;
    logic lane_q;
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            o_q     <= 1'b0;
            oe_q    <= 1'b0;
            lane_q  <= 1'b0;
            PEER_J0 <= 1'b0;
        end
        else
        begin
            oe_q    <= PEER_MASTER;
            PEER_J0 <= j0;
            if (tick)
            begin
                o_q    <= PEER_MASTER & hsfs_marker_at(12'(wrap ? 12'h000 : pos_q + 12'h001),
                                                        wrap ? 2'(mf_q + 2'd1) : mf_q);
                lane_q <= PEER_LOCKED & (pos_q == `HSFS_MATE_OFS);
            end
        end
    end
    assign link.sync_peer_o  = o_q;
    assign link.sync_peer_oe = oe_q;

    // frame marker of this slave on its own mate lane, fixed after sync
    generate
        for (genvar g = 0; g < `HSFS_MATE_LANES; g++)
        begin : g_lane
            assign link.mate_tx[g] = (g == LANE) ? lane_q : 1'b0;
        end
    endgenerate
endmodule
`default_nettype wire

// >>> testbench/hsfs_monitor.sv
// checker on the shared sync wire and mate lanes of hsfs_if
// assumes one clock domain and that both ends leave reset together
`timescale 1ns/1ps
`default_nettype none
module hsfs_monitor
(
    input wire logic                 CLK,
    input wire logic                 RST_N,
    input wire logic                 sync_dev_o,
    input wire logic                 sync_dev_oe,
    input wire logic                 sync_peer_o,
    input wire logic                 sync_peer_oe,
    input wire logic                 sync_line,
    input wire hsfs_pkg::hsfs_lane_t mate_rx,
    input wire hsfs_pkg::hsfs_lane_t mate_tx
);
    import hsfs_pkg::*;
    logic        line_q;
    logic [15:0] gap_q;
    logic [15:0] since_q;
    logic [3:0]  pc_q;
    logic [1:0]  fc_q;
    logic        j0_seen_q;
    logic        v_seen_q;
    wire         rise = sync_line & ~line_q;
    // both ends start a multiframe at reset, so the partial first frame counts as frame 0;
    // gap starts at zero so none of its markers passes for a frame marker
    wire         j0 = rise & (gap_q > 16'd3000);

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            line_q    <= 1'b0;
            gap_q     <= 16'h0000;
            since_q   <= '0;
            pc_q      <= 4'd1;
            fc_q      <= '0;
            j0_seen_q <= 1'b0;
            v_seen_q  <= 1'b0;
        end
        else
        begin
            line_q    <= sync_line;
            gap_q     <= rise ? 16'd1 : gap_q + {15'd0, gap_q != 16'hffff};
            since_q   <= j0 ? 16'd1 : since_q + {15'd0, since_q != 16'hffff};
            pc_q      <= j0 ? 4'd1 : pc_q + {3'd0, rise};
            j0_seen_q <= j0_seen_q | j0;
            if (j0)
            begin
                fc_q     <= (pc_q == 4'd14) ? 2'd0 : fc_q + 2'd1;
                v_seen_q <= v_seen_q | (pc_q == 4'd14);
            end
        end
    end

    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    pulse_width_a: assert property ($rose(sync_line) |-> sync_line[*6] ##[1:2] $fell(sync_line))
        else $error("sync pulse not one low-speed period");
    short_gap_a: assert property (rise && j0_seen_q && gap_q < 16'd3000 |-> gap_q inside {[16'd578:16'd579]})
        else $error("marker spacing wrong");
    long_gap_a: assert property (j0 && j0_seen_q |-> gap_q inside {[16'd8101:16'd8102], [16'd8680:16'd8681]})
        else $error("gap before frame marker wrong");
    frame_period_a: assert property (j0 && j0_seen_q |-> since_q == 16'd15625)
        else $error("frame marker period wrong");
    marker_count_a: assert property (j0 && j0_seen_q |-> pc_q inside {4'd13, 4'd14})
        else $error("marker count per frame wrong");
    v1_period_a: assert property (j0 && v_seen_q |-> (pc_q == 4'd14) == (fc_q == 2'd3))
        else $error("multiframe marker out of place");
    one_driver_a: assert property (!(sync_dev_oe && sync_peer_oe))
        else $error("two drivers on sync wire");
    dev_drive_a: assert property ($rose(sync_dev_o) |-> sync_dev_oe)
        else $error("sync pulse without drive enable");
    mate_quiet_a: assert property (!sync_dev_oe [*2] |-> mate_rx == '0)
        else $error("mate lane active on slave");
    mate_offset_a: assert property ($rose(mate_tx[0]) && j0_seen_q |-> since_q inside {[16'd90:16'd125]})
        else $error("mate frame not fixed after sync");

    cover property (j0 && pc_q == 4'd14);
    cover property ($rose(mate_tx[0]));
    cover property ($rose(sync_peer_o && sync_peer_oe));
    cover property ($rose(sync_dev_oe));
endmodule
`default_nettype wire

// >>> testbench/hs_frame_sync_and_clocking_tb_top.sv
// bench: mapper end and sync partner joined by hsfs_if, master then slave
// assumes src/ sources and hsfs_monitor compiled first
`timescale 1ns/1ps
`default_nettype none
module hs_frame_sync_and_clocking_tb_top;
    import hsfs_pkg::*;
    logic        CLK, RST_N, ref_ok, rx_in, rate, bypass, master, peer_master, mark, valid, prev;
    logic [4:0]  lock, cdr_ref, cdr_rate;
    hsfs_pos_t   ofs, frame_pos;
    logic        tx_ls, tprev;
    hsfs_lane_t  xc, mate_out;
    logic        mclk_ok, rx_ls, ls_tick, rx_start_n, frame_start, sync_edge, peer_locked, peer_j0;
    logic [31:0] exp_q[$], obs_q[$];
    event        got;
    int          err_total, checks, seed, n, ticks, rises, edges, d_a, trises;

    hsfs_if link ();
    hsfs_device hsfs_device_i (.CLK(CLK), .RST_N(RST_N), .TX_HS_REF_OK(ref_ok), .RX_HS_CLOCK_IN(rx_in),
        .RATE_622(rate), .CDR_BYPASS(bypass), .CDR_LOCK(lock), .SYNC_MASTER_SELECT(master),
        .TX_FRAME_OFFSET(ofs), .RX_FRAME_MARK(mark), .RX_FRAME_VALID(valid), .XC_MATE_DATA(xc),
        .CDR_REF_OK(cdr_ref), .CDR_RATE_622(cdr_rate), .FRAMER_MCLK_OK(mclk_ok), .RX_LOWSPEED_CLOCK(rx_ls),
        .TX_LOWSPEED_CLOCK(tx_ls), .TX_LS_TICK(ls_tick), .RX_FRAME_START_N(rx_start_n), .TX_FRAME_START(frame_start),
        .TX_FRAME_POS(frame_pos), .SYNC_EDGE(sync_edge), .MATE_TX_DATA(mate_out), .link(link));
    hsfs_peer #(.LANE(0)) hsfs_peer_i (.CLK(CLK), .RST_N(RST_N), .PEER_MASTER(peer_master),
        .PEER_LOCKED(peer_locked), .PEER_J0(peer_j0), .link(link));
    hsfs_monitor hsfs_monitor_i (.CLK(CLK), .RST_N(RST_N), .sync_dev_o(link.sync_dev_o),
        .sync_dev_oe(link.sync_dev_oe), .sync_peer_o(link.sync_peer_o), .sync_peer_oe(link.sync_peer_oe),
        .sync_line(link.sync_line), .mate_rx(link.mate_rx), .mate_tx(link.mate_tx));

    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            err_total++;
            $display("wrong value at %0t: got %0h, want %0h", $time, s, e);
        end
    endtask

    // the driver notes what it expects; the watcher below compares
    task automatic ex(input logic [31:0] e, input logic [31:0] s);
        exp_q.push_back(e);
        obs_q.push_back(s);
        -> got;
    endtask

    initial
        forever
        begin
            @(got);
            while (obs_q.size() != 0)
                check(obs_q.pop_front(), exp_q.pop_front());
        end

    task automatic results;
        while (obs_q.size() != 0)
            check(obs_q.pop_front(), exp_q.pop_front());
        $display("checks %0d, errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge CLK);
        #1;
    endtask

    task automatic do_reset(input logic m);
        RST_N = 1'b0;
        master = m;
        peer_master = ~m;
        cyc(12);
        RST_N = 1'b1;
        cyc(2);
    endtask

    // counts from the cycle after the current one up to and including the next frame start
    task automatic win;
        prev = rx_ls;
        tprev = tx_ls;
        {n, ticks, rises, edges, trises} = '0;
        do
        begin
            cyc(1);
            n++;
            ticks += int'(ls_tick);
            rises += int'(rx_ls & ~prev);
            trises += int'(tx_ls & ~tprev);
            edges += int'(sync_edge);
            prev = rx_ls;
            tprev = tx_ls;
        end
        while (frame_start !== 1'b1 && n < 16000);
    endtask

    task automatic count_rises(input int k);
        rises = 0;
        prev = rx_ls;
        repeat (k)
        begin
            cyc(1);
            rises += int'(rx_ls & ~prev);
            prev = rx_ls;
        end
    endtask

    // a master peer never reports a frame marker, so wait for the device's edge at frame position zero
    task automatic to_j0;
        for (int k = 0; k < 16000 && !(sync_edge === 1'b1 && frame_pos === 12'h000); k++)
            cyc(1);
    endtask

    initial
    begin
        {RST_N, rx_in, mark, xc, ref_ok} = '0;
        {rate, bypass, valid, master} = 4'hf;
        peer_master = 1'b0;
        lock = 5'h1f;
        ofs = 12'd200;
        seed = 10;
        #1;
        ex(32'h0, {cdr_ref, mclk_ok});
        ref_ok = 1'b1;
        #1;
        ex(32'h3f, {cdr_ref, mclk_ok});
        ex(32'h03, cdr_rate);
        do_reset(1'b1);
        ex(32'h1, link.sync_dev_oe);
        win();
        win();
        ex(`HSFS_FRAME_US * 1000 / `HSFS_CLK_NS, n);
        ex(`HSFS_FRAME_TICKS, ticks);
        ex(`HSFS_FRAME_TICKS, rises);
        ex(`HSFS_FRAME_TICKS, trises);
        for (n = 0; n < 16 && peer_j0 !== 1'b1; n++)
            cyc(1);
        ex(32'h1, peer_j0);
        for (n = 0; n < 16000 && mate_out[0] !== 1'b1; n++)
            cyc(1);
        ex(32'h1, peer_locked);
        ex(32'h1, mate_out[0]);
        repeat (16)
        begin
            xc = hsfs_lane_t'($random(seed));
            cyc(1);
            ex(xc, link.mate_rx);
        end
        mark = 1'b1;
        cyc(1);
        mark = 1'b0;
        for (n = 0; n < 100 && rx_start_n === 1'b0; n++)
            cyc(1);
        ex(`HSFS_RFS_CYC, n);
        {valid, mark} = 2'b01;
        cyc(1);
        mark = 1'b0;
        ex(32'h1, rx_start_n);
        valid = 1'b1;
        // 155 mode with bypass: receive clock now follows the external pin
        {rate, xc} = 4'h7;
        count_rises(30);
        count_rises(200);
        ex(32'h0, rises);
        ex(32'h0, {link.mate_rx, mate_out});
        ex(32'h0, cdr_rate);
        rx_in = 1'b1;
        count_rises(30);
        count_rises(200);
        ex(32'h1, rises inside {31, 32});
        do_reset(1'b0);
        ex(32'h0, link.sync_dev_oe);
        to_j0();
        win();
        d_a = ticks;
        // the frame marker's own edge falls before the window: only j1 markers below the offset
        ex(32'd199, ticks);
        ex(32'd2, edges);
        ofs = 12'd700;
        to_j0();
        win();
        ex(32'd500, ticks - d_a);
        ex(32'd7, edges);
        results();
    end

    initial
    begin
        #640000;
        err_total++;
        results();
    end
endmodule
`default_nettype wire
